// ==== core/uvrc_top.sv ====
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - mode 00 trips, 01 restarts from 0 Hz, 02 restarts with frequency matching.
// - mode 03 matches, decelerates to stop, then trips.
// - count setting 00 allows 16 retries, then trips.
// - count setting 01 retries forever, never trips on count.
// - undervoltage lasting 40 s trips with undervoltage error code.
// - outage within allowable time restarts; longer outage trips.
// - wait the retry wait time before restarting.
// - trip enable 00 never, 01 always, 02 not when stopped or run removed.
// - retry mode with suppressed trip still trips past allowable time.
// - mode 00 trips even when outage is within allowable time.
// - motor frequency below threshold restarts from zero instead.
// - frequency matching uses a settable current limit.
// - matching lowers frequency over a settable duration.
// - match start is held, maximum or newly commanded frequency.
// - overvoltage/overcurrent while stopping reports undervoltage code, free-runs.
// - output at most half base frequency may start from zero.
// - over current limit lowers frequency until current drops.
module uvrc_top
  import uvrc_pkg::*;
#(
  parameter int unsigned TICK_CYC = uvrc_pkg::TICK_CYCLES,
  parameter int unsigned FREQ_W   = 16
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              uv_in,
  input  wire logic              run_cmd,
  input  wire logic              motor_stopped,
  input  wire logic              ov_oc_trip,
  input  wire logic [FREQ_W-1:0] motor_freq,
  input  wire logic [FREQ_W-1:0] held_freq,
  input  wire logic [FREQ_W-1:0] max_freq,
  input  wire logic [FREQ_W-1:0] cmd_freq,
  input  wire logic [FREQ_W-1:0] base_freq,
  input  wire logic [15:0]       out_current,
  output logic                   gate_enable,
  output logic [FREQ_W-1:0]      start_freq,
  output logic                   freq_lower,
  output logic                   decel_stop_req,
  output logic                   trip_out,
  output logic                   alarm_output,
  output logic                   undervoltage_output,
  output logic [7:0]             error_code
);
  import uvrc_pkg::*;

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [15:0]    cfg_reg;
  logic [15:0]    outage_reg;
  logic [15:0]    wait_reg;
  logic [15:0]    thresh_reg;
  logic [15:0]    curlim_reg;
  logic [15:0]    decel_reg;
  logic [7:0]     addr_reg;
  logic           wr_reg;
  logic           srst_reg;
  logic           clear_reg;
  uvrc_state_type state_reg;
  logic [15:0]    ph_cnt_reg;
  logic [4:0]     retry_cnt_reg;
  logic           tick;
  logic [15:0]    uv_cnt;

  // field decode used by the sequencer; the bus reads cfg_reg whole
  function automatic logic [1:0] fld2(input logic [15:0] v, input int unsigned lsb);
    fld2 = v[lsb +: 2];
  endfunction

  logic [1:0] mode;
  logic [1:0] tripen;
  logic       cnt_sel;
  logic [1:0] start_sel;
  assign mode      = fld2(cfg_reg, CFG_MODE_LSB);
  assign tripen    = fld2(cfg_reg, CFG_TRIPEN_LSB);
  assign cnt_sel   = cfg_reg[CFG_CNT_BIT];
  assign start_sel = fld2(cfg_reg, CFG_START_LSB);

  // ---------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ---------------------------------------------------------------
  logic addr_ok;
  logic [31:0] rd_mux;
  assign addr_ok = hsel && htrans[1] && hready;

  // read data latched in the address phase so it comes from a flop
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (haddr[7:0] == ADDR_CFG)
      rd_mux[15:0] = cfg_reg;
    else if (haddr[7:0] == ADDR_OUTAGE)
      rd_mux[15:0] = outage_reg;
    else if (haddr[7:0] == ADDR_WAIT)
      rd_mux[15:0] = wait_reg;
    else if (haddr[7:0] == ADDR_THRESH)
      rd_mux[15:0] = thresh_reg;
    else if (haddr[7:0] == ADDR_CURLIM)
      rd_mux[15:0] = curlim_reg;
    else if (haddr[7:0] == ADDR_DECEL)
      rd_mux[15:0] = decel_reg;
    else if (haddr[7:0] == ADDR_STATUS)
      rd_mux = {8'h00, error_code, 3'h0, retry_cnt_reg,
                5'h00, 3'(state_reg)};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_reg  <= 8'h00;
      wr_reg    <= 1'b0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_reg <= addr_ok && hwrite;
      if (addr_ok)
      begin
        addr_reg <= haddr[7:0];
        hrdata   <= hwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // settings writes; unmapped writes are dropped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_reg    <= RST_CFG;
      outage_reg <= RST_OUTAGE;
      wait_reg   <= RST_WAIT;
      thresh_reg <= RST_THRESH;
      curlim_reg <= RST_CURLIM;
      decel_reg  <= RST_DECEL;
    end
    else if (wr_reg)
    begin
      if (addr_reg == ADDR_CFG)
        cfg_reg <= hwdata[15:0];
      else if (addr_reg == ADDR_OUTAGE)
        outage_reg <= hwdata[15:0];
      else if (addr_reg == ADDR_WAIT)
        wait_reg <= hwdata[15:0];
      else if (addr_reg == ADDR_THRESH)
        thresh_reg <= hwdata[15:0];
      else if (addr_reg == ADDR_CURLIM)
        curlim_reg <= hwdata[15:0];
      else if (addr_reg == ADDR_DECEL)
        decel_reg <= hwdata[15:0];
    end
  end

  // control strobes, one cycle each
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clear_reg <= 1'b0;
      srst_reg  <= 1'b0;
    end
    else
    begin
      clear_reg <= wr_reg && (addr_reg == ADDR_CTRL) && hwdata[CTRL_CLEAR_BIT];
      srst_reg  <= wr_reg && (addr_reg == ADDR_CTRL) && hwdata[CTRL_SRST_BIT];
    end
  end

  // ---------------------------------------------------------------
  // timebase and continuous undervoltage timer
  // ---------------------------------------------------------------
  // tenth-second tick
  uvrc_tick #(.CYC(TICK_CYC)) u_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .srst    (srst_reg),
    .tick    (tick)
  );

  uvrc_timer #(.W(TMR_W)) u_uv_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clr     (!uv_in || srst_reg),
    .tick    (tick),
    .count   (uv_cnt)
  );

  // ---------------------------------------------------------------
  // restart sequencer
  // ---------------------------------------------------------------
  logic suppress;
  logic uv_long;
  logic over_lim;
  logic zero_start;
  logic [FREQ_W-1:0] match_freq;

  // trip suppression always with trip enable 00, and with 02 while stopped or with run removed
  assign suppress = (tripen == TRIPEN_NEVER) ||
                    ((tripen == TRIPEN_RUN_ONLY) && (motor_stopped || !run_cmd));
  assign uv_long  = (uv_cnt >= UV_LIMIT_TICKS);
  assign over_lim = (out_current > curlim_reg);
  // threshold and half-base fall back to zero start
  assign zero_start = (mode == MODE_ZERO) ||
                      (motor_freq < FREQ_W'(thresh_reg)) ||
                      (held_freq <= (base_freq >> 1));
  assign match_freq = (start_sel == START_HELD) ? held_freq :
                      (start_sel == START_MAX)  ? max_freq  : cmd_freq;

  // trip and error flags live with the state, so a trip in the clear
  // cycle is never lost: clear only acts while already tripped
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg      <= ST_RUN;
      ph_cnt_reg     <= 16'h0000;
      retry_cnt_reg  <= 5'h00;
      gate_enable    <= 1'b1;
      start_freq     <= '0;
      freq_lower     <= 1'b0;
      decel_stop_req <= 1'b0;
      trip_out       <= 1'b0;
      error_code     <= 8'h00;
    end
    else
    begin
      if (srst_reg)
        ph_cnt_reg <= 16'h0000;
      else if (tick && (ph_cnt_reg != 16'hFFFF))
        ph_cnt_reg <= ph_cnt_reg + 1'b1;
      if (uv_long && (state_reg != ST_TRIP))
      begin
        state_reg   <= ST_TRIP;
        trip_out    <= 1'b1;
        error_code  <= UV_ERR_CODE;
        gate_enable <= 1'b0;
        freq_lower  <= 1'b0;
        decel_stop_req <= 1'b0;
      end
      else
      begin
        case (state_reg)
          ST_RUN:
          begin
            // trip mode trips on the outage itself
            if (uv_in && (mode == MODE_TRIP) && !suppress)
            begin
              state_reg   <= ST_TRIP;
              trip_out    <= 1'b1;
              error_code  <= UV_ERR_CODE;
              gate_enable <= 1'b0;
            end
            else if (uv_in)
            begin
              state_reg   <= ST_OUTAGE;
              ph_cnt_reg  <= 16'h0000;
              gate_enable <= 1'b0;
            end
          end
          ST_OUTAGE:
          begin
            if (ph_cnt_reg > outage_reg)
            begin
              state_reg  <= ST_TRIP;
              trip_out   <= 1'b1;
              error_code <= UV_ERR_CODE;
            end
            else if (!uv_in && (mode == MODE_TRIP))
            begin
              state_reg   <= ST_RUN;
              gate_enable <= 1'b1;
            end
            else if (!uv_in && (cnt_sel == CNT_LIMITED) &&
                     (retry_cnt_reg == RETRY_MAX))
            begin
              state_reg  <= ST_TRIP;
              trip_out   <= 1'b1;
              error_code <= UV_ERR_CODE;
            end
            // unlimited mode never counts towards a trip
            else if (!uv_in)
            begin
              state_reg  <= ST_WAIT;
              ph_cnt_reg <= 16'h0000;
              if (cnt_sel == CNT_LIMITED)
                retry_cnt_reg <= retry_cnt_reg + 1'b1;
            end
          end
          ST_WAIT:
          begin
            if (uv_in)
            begin
              state_reg  <= ST_OUTAGE;
              ph_cnt_reg <= 16'h0000;
            end
            // restart only after the retry wait
            else if (ph_cnt_reg >= wait_reg)
            begin
              gate_enable <= 1'b1;
              ph_cnt_reg  <= 16'h0000;
              if (zero_start)
              begin
                state_reg  <= ST_RUN;
                start_freq <= '0;
              end
              else
              begin
                state_reg  <= ST_MATCH;
                start_freq <= match_freq;
              end
            end
          end
          ST_MATCH:
          begin
            // lower frequency while current is over limit
            freq_lower <= over_lim;
            if (uv_in)
            begin
              state_reg   <= ST_OUTAGE;
              ph_cnt_reg  <= 16'h0000;
              gate_enable <= 1'b0;
              freq_lower  <= 1'b0;
            end
            // lowering ends with current or duration
            else if (!over_lim || (ph_cnt_reg >= decel_reg))
            begin
              freq_lower <= 1'b0;
              if (mode == MODE_MATCH_STOP)
              begin
                state_reg      <= ST_DECEL;
                decel_stop_req <= 1'b1;
              end
              else
                state_reg <= ST_RUN;
            end
          end
          ST_DECEL:
          begin
            // fault while stopping: free-run with uv code
            if (ov_oc_trip)
            begin
              state_reg      <= ST_TRIP;
              trip_out       <= 1'b1;
              error_code     <= UV_ERR_CODE;
              gate_enable    <= 1'b0;
              decel_stop_req <= 1'b0;
            end
            // stopped after matching restart, then trip
            else if (motor_stopped)
            begin
              state_reg      <= ST_TRIP;
              trip_out       <= 1'b1;
              error_code     <= UV_ERR_CODE;
              gate_enable    <= 1'b0;
              decel_stop_req <= 1'b0;
            end
          end
          ST_TRIP:
          begin
            if (clear_reg)
            begin
              state_reg     <= ST_RUN;
              trip_out      <= 1'b0;
              error_code    <= 8'h00;
              retry_cnt_reg <= 5'h00;
              gate_enable   <= 1'b1;
            end
          end
          default:
            state_reg <= ST_TRIP;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // status pins
  // ---------------------------------------------------------------
  // alarm and undervoltage relays mirror trip and supply state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      alarm_output        <= 1'b0;
      undervoltage_output <= 1'b0;
    end
    else
    begin
      alarm_output        <= (state_reg == ST_TRIP);
      undervoltage_output <= uv_in;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_forty_sec_trip:
    assert property (uv_long && state_reg != ST_TRIP |=>
                     state_reg == ST_TRIP && error_code == UV_ERR_CODE)
    else $error("continuous undervoltage did not trip");
  a_outage_exceed_trip:
    assert property (!uv_long && state_reg == ST_OUTAGE && ph_cnt_reg > outage_reg
                     |=> trip_out)
    else $error("outage past allowable time did not trip");
  a_retry_count_limit:
    assert property (!uv_long && state_reg == ST_OUTAGE && !uv_in &&
                     ph_cnt_reg <= outage_reg && mode != MODE_TRIP &&
                     cnt_sel == CNT_LIMITED && retry_cnt_reg == RETRY_MAX
                     |=> state_reg == ST_TRIP)
    else $error("retry limit did not trip");
  a_unlimited_retry:
    assert property (!uv_long && state_reg == ST_OUTAGE && !uv_in &&
                     ph_cnt_reg <= outage_reg && mode != MODE_TRIP &&
                     cnt_sel != CNT_LIMITED |=> state_reg == ST_WAIT)
    else $error("unlimited retry tripped");
  a_mode_trip_uv:
    assert property (!uv_long && state_reg == ST_RUN && uv_in &&
                     mode == MODE_TRIP && !suppress |=> trip_out ##1 alarm_output)
    else $error("trip mode did not trip");
  a_retry_wait_hold:
    assert property (!uv_long && state_reg == ST_WAIT && !uv_in &&
                     ph_cnt_reg < wait_reg |=> state_reg == ST_WAIT && !gate_enable)
    else $error("restart before retry wait");
  a_zero_restart:
    assert property (!uv_long && state_reg == ST_WAIT && !uv_in &&
                     ph_cnt_reg >= wait_reg && zero_start
                     |=> state_reg == ST_RUN && start_freq == '0 && gate_enable)
    else $error("zero-frequency restart missed");
  a_decel_fault_freerun:
    assert property (!uv_long && state_reg == ST_DECEL && ov_oc_trip
                     |=> !gate_enable && error_code == UV_ERR_CODE)
    else $error("fault while stopping not free-run");
  a_stop_then_trip:
    assert property (!uv_long && state_reg == ST_DECEL && motor_stopped
                     |=> state_reg == ST_TRIP && !decel_stop_req)
    else $error("stop did not trip");
  a_current_lowering:
    assert property (!uv_long && state_reg == ST_MATCH && !uv_in && over_lim &&
                     ph_cnt_reg < decel_reg |=> freq_lower)
    else $error("over-limit current not lowered");
endmodule // uvrc_top
`default_nettype wire

// ==== core/uvrc_pkg.sv ====
package uvrc_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned TICK_PERIOD_NS = 100_000_000;
  localparam int unsigned TICK_CYCLES    =
    (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TICKS_PER_S    = 10;
  localparam int unsigned UV_LIMIT_S     = 40;
  localparam int unsigned TMR_W          = 16;
  localparam logic [15:0] UV_LIMIT_TICKS = 16'(UV_LIMIT_S * TICKS_PER_S);
  localparam logic [4:0]  RETRY_MAX      = 5'h10;
  localparam logic [7:0]  UV_ERR_CODE    = 8'h09;

  // ---------------------------------------------------------------
  // setting encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_TRIP       = 2'h0;
  localparam logic [1:0] MODE_ZERO       = 2'h1;
  localparam logic [1:0] MODE_MATCH      = 2'h2;
  localparam logic [1:0] MODE_MATCH_STOP = 2'h3;
  localparam logic [1:0] TRIPEN_NEVER    = 2'h0;
  localparam logic [1:0] TRIPEN_RUN_ONLY = 2'h2;
  localparam logic       CNT_LIMITED     = 1'b0;
  localparam logic [1:0] START_HELD      = 2'h0;
  localparam logic [1:0] START_MAX       = 2'h1;

  // ---------------------------------------------------------------
  // register map and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG     = 8'h00;
  localparam logic [7:0] ADDR_OUTAGE  = 8'h04;
  localparam logic [7:0] ADDR_WAIT    = 8'h08;
  localparam logic [7:0] ADDR_THRESH  = 8'h0C;
  localparam logic [7:0] ADDR_CURLIM  = 8'h10;
  localparam logic [7:0] ADDR_DECEL   = 8'h14;
  localparam logic [7:0] ADDR_STATUS  = 8'h18;
  localparam logic [7:0] ADDR_CTRL    = 8'h1C;
  localparam int unsigned CFG_MODE_LSB   = 0;
  localparam int unsigned CFG_TRIPEN_LSB = 4;
  localparam int unsigned CFG_CNT_BIT    = 8;
  localparam int unsigned CFG_START_LSB  = 12;
  localparam int unsigned CTRL_CLEAR_BIT = 0;
  localparam int unsigned CTRL_SRST_BIT  = 1;
  localparam logic [15:0] RST_CFG     = 16'h0000;
  localparam logic [15:0] RST_OUTAGE  = 16'h000A;
  localparam logic [15:0] RST_WAIT    = 16'h000A;
  localparam logic [15:0] RST_THRESH  = 16'h0000;
  localparam logic [15:0] RST_CURLIM  = 16'h0064;
  localparam logic [15:0] RST_DECEL   = 16'h0005;

  typedef enum logic [2:0] {
    ST_RUN, ST_OUTAGE, ST_WAIT, ST_MATCH, ST_DECEL, ST_TRIP
  } uvrc_state_type;
endpackage

// ==== core/uvrc_tick.sv ====
`timescale 1ns/1ns
`default_nettype none
module uvrc_tick #(
  parameter int unsigned CYC = 2
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic srst,
  output logic      tick
);
  localparam int unsigned CW = (CYC > 1) ? $clog2(CYC) : 1;
  logic [CW-1:0] cnt_reg;

  // divider, synchronous clear restarts the tenth-second phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end
    else if (srst)
    begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end
    else if (cnt_reg == CW'(CYC - 1))
    begin
      cnt_reg <= '0;
      tick    <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 1'b1;
      tick    <= 1'b0;
    end
  end
endmodule // uvrc_tick
`default_nettype wire

// ==== core/uvrc_timer.sv ====
`timescale 1ns/1ns
`default_nettype none
module uvrc_timer #(
  parameter int unsigned W = 16
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         clr,
  input  wire logic         tick,
  output logic [W-1:0]      count
);
  // saturating tick counter, so a long outage never wraps to zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count <= '0;
    else if (clr)
      count <= '0;
    else if (tick && (count != {W{1'b1}}))
      count <= count + 1'b1;
  end
endmodule // uvrc_timer
`default_nettype wire

// ==== verif/uvrc_plant.sv ====
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// motor, stage and sensing model
// ------------------------------
module uvrc_plant (
  input  wire logic   hclk,
  input  wire logic   hresetn,
  input  wire logic   gate_enable,
  input  wire logic   freq_lower,
  input  wire logic   decel_stop_req,
  output logic        motor_stopped,
  output logic [15:0] out_current,
  output logic [15:0] motor_freq
);
  logic [3:0] stop_cnt;

  // coasting slows the motor; a fresh restart draws inrush until lowered
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      motor_freq  <= 16'h0200;
      out_current <= 16'h0032;
    end
    else if (!gate_enable)
    begin
      motor_freq  <= (motor_freq != 16'h0000) ? motor_freq - 16'h0001 : motor_freq;
      out_current <= 16'h00C8;
    end
    else if (freq_lower)
      out_current <= 16'h0032;
  end

  // standstill comes late on purpose, so faults can land first
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      stop_cnt <= 4'h0;
    else if (!decel_stop_req)
      stop_cnt <= 4'h0;
    else if (stop_cnt != 4'hF)
      stop_cnt <= stop_cnt + 4'h1;
  end
  assign motor_stopped = (stop_cnt == 4'hF);
endmodule // uvrc_plant
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb;
  import uvrc_pkg::*;
  // ------------------------------
  // signals
  // ------------------------------
  localparam logic [15:0] HELD = 16'h0100, MAXF = 16'h0300, CMDF = 16'h0180;
  localparam logic [15:0] RV [7] = '{RST_CFG, RST_OUTAGE, RST_WAIT, RST_THRESH,
                                     RST_CURLIM, RST_DECEL, 16'h0000};
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
  logic        uv_in = 1'b0, run_cmd = 1'b1, ov_oc_trip = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic        hreadyout, hresp, motor_stopped, gate_enable, freq_lower;
  logic        decel_stop_req, trip_out, alarm_output, undervoltage_output;
  logic [15:0] motor_freq, out_current, start_freq;
  logic [15:0] base = 16'h0100;
  logic [7:0]  error_code;
  int          fail_count = 0, samples_checked = 0, cyc = 0;

  assign hready = hreadyout;
  // 50 ns clock
  always #25 hclk = ~hclk;

  // short tick so that a second becomes 40 cycles
  uvrc_top #(.TICK_CYC(4)) i_uvrc_top (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .uv_in, .run_cmd, .motor_stopped, .ov_oc_trip, .motor_freq,
    .held_freq(HELD), .max_freq(MAXF), .cmd_freq(CMDF), .base_freq(base),
    .out_current, .gate_enable, .start_freq, .freq_lower, .decel_stop_req, .trip_out,
    .alarm_output, .undervoltage_output, .error_code);
  uvrc_plant i_uvrc_plant (
    .hclk, .hresetn, .gate_enable, .freq_lower, .decel_stop_req, .motor_stopped,
    .out_current, .motor_freq);

  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic close_out();
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask

  // one single word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  // bounded wait: 0 gate on, 1 tripped, 2 stop request, 3 lowering
  task automatic wt(input int k);
    logic [3:0] v;
    for (int i = 0; i < 3000; i++)
    begin
      @(posedge hclk);
      #1 v = {freq_lower, decel_stop_req, trip_out, gate_enable};
      if (v[k] === 1'b1)
        return;
    end
  endtask

  task automatic clr();
    bus(1'b1, ADDR_CTRL, 32'h1);
    repeat (2) @(posedge hclk);
    #1 chk(trip_out, 1'b0);
  endtask

  // brief dip that must end in a restart
  task automatic pulse(input logic [15:0] cfg, input logic [15:0] th, input logic [15:0] e);
    bus(1'b1, ADDR_CFG, {16'h0, cfg});
    bus(1'b1, ADDR_THRESH, {16'h0, th});
    @(posedge hclk);
    uv_in <= 1'b1;
    @(posedge hclk);
    #1 chk(undervoltage_output, 1'b1);
    @(posedge hclk);
    uv_in <= 1'b0;
    repeat (8) @(posedge hclk);
    #1 chk(gate_enable, 1'b0);
    wt(0);
    chk(start_freq, e);
    chk(trip_out, 1'b0);
    if (e != 16'h0000)
    begin
      wt(3);
      chk(freq_lower, 1'b1);
    end
    repeat (40) @(posedge hclk);
  endtask

  // dip of up cycles that must trip, not before lo cycles
  task automatic hold(input logic [15:0] cfg, input int up, input int lo);
    bus(1'b1, ADDR_CFG, {16'h0, cfg});
    @(posedge hclk);
    uv_in <= 1'b1;
    repeat (lo) @(posedge hclk);
    #1 chk(trip_out, 1'b0);
    repeat (up - lo) @(posedge hclk);
    uv_in <= 1'b0;
    repeat (3) @(posedge hclk);
    #1 chk(trip_out, 1'b1);
    chk(error_code, UV_ERR_CODE);
    chk(alarm_output, 1'b1);
    chk(undervoltage_output, 1'b0);
    clr();
  endtask

  // matching restart then stop; f injects a fault before standstill
  task automatic mstop(input logic f);
    bus(1'b1, ADDR_CFG, 32'h3);
    @(posedge hclk);
    uv_in <= 1'b1;
    repeat (2) @(posedge hclk);
    uv_in <= 1'b0;
    wt(2);
    chk(decel_stop_req, 1'b1);
    @(posedge hclk);
    ov_oc_trip <= f;
    @(posedge hclk);
    ov_oc_trip <= 1'b0;
    repeat (2) @(posedge hclk);
    #1 chk(trip_out, f);
    wt(1);
    chk(trip_out, 1'b1);
    chk(gate_enable, 1'b0);
    chk(error_code, UV_ERR_CODE);
    chk(decel_stop_req, 1'b0);
    clr();
  endtask

  // hang guard
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      fail_count++;
      close_out();
    end
  end

  // ------------------------------
  // scenarios
  // ------------------------------
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int a = 0; a < 7; a++)
    begin
      bus(1'b0, 8'(a * 4), 32'h0);
      chk(rd, 32'(RV[a]));
    end
    bus(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk({hresp, hreadyout}, 2'b01);
    bus(1'b1, ADDR_WAIT, 32'h3);
    pulse(16'h0001, 16'h0000, 16'h0000);
    pulse(16'h0002, 16'h0000, HELD);
    pulse(16'h1002, 16'h0000, MAXF);
    pulse(16'h2002, 16'h0000, CMDF);
    pulse(16'h0002, 16'hFFFF, 16'h0000);
    // held output at most half base starts from zero
    base <= 16'h0300;
    pulse(16'h0002, 16'h0000, 16'h0000);
    base <= 16'h0100;
    // trip mode on a brief dip
    hold(16'h0010, 3, 0);
    // setting 02 suppresses with run removed, trips while running
    bus(1'b1, ADDR_CFG, 32'h0020);
    run_cmd <= 1'b0;
    @(posedge hclk);
    uv_in <= 1'b1;
    repeat (2) @(posedge hclk);
    uv_in <= 1'b0;
    repeat (3) @(posedge hclk);
    #1 chk(trip_out, 1'b0);
    chk(gate_enable, 1'b1);
    @(posedge hclk);
    run_cmd <= 1'b1;
    hold(16'h0020, 3, 0);
    // sixteen retries, the next one trips
    repeat (16) pulse(16'h0001, 16'h0000, 16'h0000);
    hold(16'h0001, 3, 0);
    repeat (17) pulse(16'h0101, 16'h0000, 16'h0000);
    hold(16'h0002, 60, 30);
    // continuous undervoltage beats a huge allowance
    bus(1'b1, ADDR_OUTAGE, 32'h0FFF);
    hold(16'h0001, 1625, 1560);
    // stop then trip, fault while stopping
    mstop(1'b0);
    mstop(1'b1);
    close_out();
  end
endmodule // tb
`default_nettype wire
